// ==== include/mfirq_pkg.sv ====
// package for the multi-function interrupt register slice
// assumes an 8-bit register port and single-cycle peripheral event pulses
package mfirq_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] MFIRQ_ADDR_HI_CTRL    = 4'h0;
    localparam logic [3:0] MFIRQ_ADDR_TMR0_CTRL  = 4'h1;
    localparam logic [3:0] MFIRQ_ADDR_PERIPH     = 4'h2;
    localparam logic [3:0] MFIRQ_ADDR_GLOBAL     = 4'h3;
    localparam logic [3:0] MFIRQ_ADDR_STATUS     = 4'h4;
    localparam logic [3:0] MFIRQ_ADDR_MASK       = 4'h5;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MFIRQ_HI_FLAG  = 5;   // group3 / cmpa flag position
    localparam int MFIRQ_LO_FLAG  = 4;   // group2 / cmpp flag position
    localparam int MFIRQ_HI_EN    = 1;
    localparam int MFIRQ_LO_EN    = 0;
    localparam int MFIRQ_PF_LSB   = 4;   // peripheral flags 7..4
    localparam int MFIRQ_PE_LSB   = 0;   // peripheral enables 3..0
    localparam int MFIRQ_NPER     = 4;
    localparam int MFIRQ_NEV      = 6;   // status event bits
    localparam logic [7:0] MFIRQ_PAIR_MASK = 8'h33;
    localparam logic [7:0] MFIRQ_RESET     = 8'h00;
    localparam logic [7:0] MFIRQ_ZERO      = 8'h00;

    // ------------------------------------------------------------------
    // bus request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mfirq_bus_t;

    // peripheral event pulses: uart, serial, eeprom, low voltage (7..4 order)
    typedef struct packed {
        logic       tmr0_cmpa;
        logic       tmr0_cmpp;
        logic [3:0] periph;
    } mfirq_evt_t;
endpackage

// ==== hw/mfirq_regs.sv ====
// multi-function interrupt 2/3 control and sub-source registers
// assumes a single-cycle register port and same-clock event pulses
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module mfirq_regs (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire mfirq_pkg::mfirq_bus_t bus,
    output logic [7:0]                rdata,
    input  wire mfirq_pkg::mfirq_evt_t evt,
    output logic                      group2_irq,
    output logic                      group3_irq,
    output logic                      irq
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    logic [7:0] hi_ctrl;
    logic [7:0] tmr_ctrl;
    logic [7:0] per_ctrl;
    logic       global_irq_enable;
    logic [5:0] status;
    logic [5:0] mask;

    wire w_hi  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_HI_CTRL);
    wire w_tm  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_TMR0_CTRL);
    wire w_pe  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_PERIPH);
    wire w_gl  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_GLOBAL);
    wire w_st  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_STATUS);
    wire w_mk  = bus.wr && hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_MASK);

    // ------------------------------------------------------------------
    // sub-source flags
    // ------------------------------------------------------------------
    wire [7:0] tm_base = w_tm ? (bus.wdata & mfirq_pkg::MFIRQ_PAIR_MASK) : tmr_ctrl;
    wire [7:0] set_tm  = {2'h0, evt.tmr0_cmpa, evt.tmr0_cmpp, 4'h0};
    wire [7:0] next_tmr_ctrl = tm_base | set_tm;

    wire [7:0] pe_base = w_pe ? bus.wdata : per_ctrl;
    wire [7:0] next_per_ctrl = pe_base | {evt.periph, 4'h0};

    // group requests from enabled sub-sources
    wire grp2_src = (tmr_ctrl[mfirq_pkg::MFIRQ_HI_FLAG] & tmr_ctrl[mfirq_pkg::MFIRQ_HI_EN])
                  | (tmr_ctrl[mfirq_pkg::MFIRQ_LO_FLAG] & tmr_ctrl[mfirq_pkg::MFIRQ_LO_EN]);
    wire grp3_src = |(per_ctrl[7:mfirq_pkg::MFIRQ_PF_LSB]
                      & per_ctrl[mfirq_pkg::MFIRQ_NPER-1:mfirq_pkg::MFIRQ_PE_LSB]);

    // set wins over a software clear in the same cycle
    wire [7:0] hi_base = w_hi ? (bus.wdata & mfirq_pkg::MFIRQ_PAIR_MASK) : hi_ctrl;
    wire [7:0] next_hi_ctrl = hi_base | {2'h0, grp3_src, grp2_src, 4'h0};

    // ------------------------------------------------------------------
    // requests to the core
    // ------------------------------------------------------------------
    wire next_g2 = global_irq_enable & hi_ctrl[mfirq_pkg::MFIRQ_LO_FLAG]
                 & hi_ctrl[mfirq_pkg::MFIRQ_LO_EN];
    wire next_g3 = global_irq_enable & hi_ctrl[mfirq_pkg::MFIRQ_HI_FLAG]
                 & hi_ctrl[mfirq_pkg::MFIRQ_HI_EN];

    // sticky status: cmpa, cmpp, periph[3:0]; write one to clear, set wins
    wire [5:0] ev_vec   = {evt.tmr0_cmpa, evt.tmr0_cmpp, evt.periph};
    wire [5:0] st_clr   = w_st ? bus.wdata[5:0] : 6'h00;
    wire [5:0] next_status = (status & ~st_clr) | ev_vec;
    wire [5:0] next_mask   = w_mk ? bus.wdata[5:0] : mask;
    wire       next_irq    = |(status & mask);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [7:0] next_rdata =
        !bus.rd                                              ? mfirq_pkg::MFIRQ_ZERO :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_HI_CTRL)   ? hi_ctrl  :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_TMR0_CTRL) ? tmr_ctrl :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_PERIPH)    ? per_ctrl :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_GLOBAL)    ? {7'h00, global_irq_enable} :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_STATUS)    ? {2'h0, status} :
        hit(bus.addr, mfirq_pkg::MFIRQ_ADDR_MASK)      ? {2'h0, mask} :
                                                          mfirq_pkg::MFIRQ_ZERO;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_ctrl           <= mfirq_pkg::MFIRQ_RESET;
            tmr_ctrl          <= mfirq_pkg::MFIRQ_RESET;
            per_ctrl          <= mfirq_pkg::MFIRQ_RESET;
            global_irq_enable <= 1'b0;
            status            <= 6'h00;
            mask              <= 6'h00;
            rdata             <= mfirq_pkg::MFIRQ_ZERO;
            group2_irq        <= 1'b0;
            group3_irq        <= 1'b0;
            irq               <= 1'b0;
        end else begin
            hi_ctrl           <= next_hi_ctrl;
            tmr_ctrl          <= next_tmr_ctrl;
            per_ctrl          <= next_per_ctrl;
            global_irq_enable <= w_gl ? bus.wdata[0] : global_irq_enable;
            status            <= next_status;
            mask              <= next_mask;
            rdata             <= next_rdata;
            group2_irq        <= next_g2;
            group3_irq        <= next_g3;
            irq               <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_unimpl_zero;
        @(posedge mclk) disable iff (!rst_n)
        ((hi_ctrl | tmr_ctrl) & ~mfirq_pkg::MFIRQ_PAIR_MASK) == 8'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_cmpa_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.tmr0_cmpa |=> tmr_ctrl[5];
    endproperty
    a_cmpa_set: assert property (p_cmpa_set) else $error("cmpa flag not set");

    property p_cmpp_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.tmr0_cmpp |=> tmr_ctrl[4];
    endproperty
    a_cmpp_set: assert property (p_cmpp_set) else $error("cmpp flag not set");

    property p_per_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.periph[3] |=> per_ctrl[7];
    endproperty
    a_per_set: assert property (p_per_set) else $error("uart flag not set");

    property p_grp2_from_tmr;
        @(posedge mclk) disable iff (!rst_n)
        (tmr_ctrl[5] && tmr_ctrl[1]) |=> hi_ctrl[4];
    endproperty
    a_grp2_from_tmr: assert property (p_grp2_from_tmr) else $error("group2 not raised");

    property p_grp3_from_per;
        @(posedge mclk) disable iff (!rst_n)
        (per_ctrl[7] && per_ctrl[3]) |=> hi_ctrl[5];
    endproperty
    a_grp3_from_per: assert property (p_grp3_from_per) else $error("group3 not raised");

    property p_g2_gate;
        @(posedge mclk) disable iff (!rst_n)
        group2_irq |-> $past(global_irq_enable) && $past(hi_ctrl[0]) && $past(hi_ctrl[4]);
    endproperty
    a_g2_gate: assert property (p_g2_gate) else $error("group2 request ungated");

    property p_g3_gate;
        @(posedge mclk) disable iff (!rst_n)
        (global_irq_enable && hi_ctrl[1] && hi_ctrl[5]) |=> group3_irq;
    endproperty
    a_g3_gate: assert property (p_g3_gate) else $error("group3 request missing");

    property p_rd_latency;
        @(posedge mclk) disable iff (!rst_n)
        (bus.rd && bus.addr == mfirq_pkg::MFIRQ_ADDR_HI_CTRL) |=> rdata == $past(hi_ctrl);
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read data wrong");

    // ------------------------------------------------------------------
    // further checks on sub-sources, grouping, status, mask, irq and the read port
    // ------------------------------------------------------------------
    property p_ser_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.periph[2] |=> per_ctrl[6];
    endproperty
    a_ser_set: assert property (p_ser_set) else $error("serial flag not set");

    property p_eep_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.periph[1] |=> per_ctrl[5];
    endproperty
    a_eep_set: assert property (p_eep_set) else $error("eeprom flag not set");

    property p_lv_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.periph[0] |=> per_ctrl[4];
    endproperty
    a_lv_set: assert property (p_lv_set) else $error("low voltage flag not set");

    property p_grp2_from_cmpp;
        @(posedge mclk) disable iff (!rst_n)
        (tmr_ctrl[4] && tmr_ctrl[0]) |=> hi_ctrl[4];
    endproperty
    a_grp2_from_cmpp: assert property (p_grp2_from_cmpp) else $error("group2 not raised");

    property p_grp3_from_ser;
        @(posedge mclk) disable iff (!rst_n)
        (per_ctrl[6] && per_ctrl[2]) |=> hi_ctrl[5];
    endproperty
    a_grp3_from_ser: assert property (p_grp3_from_ser) else $error("group3 not raised");

    property p_grp3_from_eep;
        @(posedge mclk) disable iff (!rst_n)
        (per_ctrl[5] && per_ctrl[1]) |=> hi_ctrl[5];
    endproperty
    a_grp3_from_eep: assert property (p_grp3_from_eep) else $error("group3 not raised");

    property p_grp3_from_lv;
        @(posedge mclk) disable iff (!rst_n)
        (per_ctrl[4] && per_ctrl[0]) |=> hi_ctrl[5];
    endproperty
    a_grp3_from_lv: assert property (p_grp3_from_lv) else $error("group3 not raised");

    property p_g3_only_gated;
        @(posedge mclk) disable iff (!rst_n)
        group3_irq |-> $past(global_irq_enable) && $past(hi_ctrl[1]) && $past(hi_ctrl[5]);
    endproperty
    a_g3_only_gated: assert property (p_g3_only_gated) else $error("group3 ungated");

    property p_g2_on;
        @(posedge mclk) disable iff (!rst_n)
        (global_irq_enable && hi_ctrl[0] && hi_ctrl[4]) |=> group2_irq;
    endproperty
    a_g2_on: assert property (p_g2_on) else $error("group2 request missing");

    property p_cmpa_hold;
        @(posedge mclk) disable iff (!rst_n)
        (!w_tm && tmr_ctrl[5]) |=> tmr_ctrl[5];
    endproperty
    a_cmpa_hold: assert property (p_cmpa_hold) else $error("cmpa flag lost");

    property p_cmpp_hold;
        @(posedge mclk) disable iff (!rst_n)
        (!w_tm && tmr_ctrl[4]) |=> tmr_ctrl[4];
    endproperty
    a_cmpp_hold: assert property (p_cmpp_hold) else $error("cmpp flag lost");

    property p_hi_wr;
        @(posedge mclk) disable iff (!rst_n)
        (w_hi && !grp2_src && !grp3_src)
            |=> hi_ctrl == ($past(bus.wdata) & mfirq_pkg::MFIRQ_PAIR_MASK);
    endproperty
    a_hi_wr: assert property (p_hi_wr) else $error("hi control write lost");

    property p_tm_wr;
        @(posedge mclk) disable iff (!rst_n)
        (w_tm && !evt.tmr0_cmpa && !evt.tmr0_cmpp)
            |=> tmr_ctrl == ($past(bus.wdata) & mfirq_pkg::MFIRQ_PAIR_MASK);
    endproperty
    a_tm_wr: assert property (p_tm_wr) else $error("timer0 control write lost");

    property p_pe_wr;
        @(posedge mclk) disable iff (!rst_n)
        (w_pe && evt.periph == 4'h0) |=> per_ctrl == $past(bus.wdata);
    endproperty
    a_pe_wr: assert property (p_pe_wr) else $error("peripheral control write lost");

    property p_hi_en_keep;
        @(posedge mclk) disable iff (!rst_n)
        !w_hi |=> hi_ctrl[1:0] == $past(hi_ctrl[1:0]);
    endproperty
    a_hi_en_keep: assert property (p_hi_en_keep) else $error("group enable moved");

    property p_tm_en_keep;
        @(posedge mclk) disable iff (!rst_n)
        !w_tm |=> tmr_ctrl[1:0] == $past(tmr_ctrl[1:0]);
    endproperty
    a_tm_en_keep: assert property (p_tm_en_keep) else $error("timer0 enable moved");

    property p_pe_en_keep;
        @(posedge mclk) disable iff (!rst_n)
        !w_pe |=> per_ctrl[3:0] == $past(per_ctrl[3:0]);
    endproperty
    a_pe_en_keep: assert property (p_pe_en_keep) else $error("peripheral enable moved");

    property p_no_global;
        @(posedge mclk) disable iff (!rst_n)
        !global_irq_enable |=> !group2_irq && !group3_irq;
    endproperty
    a_no_global: assert property (p_no_global) else $error("request without global");

    property p_status_set;
        @(posedge mclk) disable iff (!rst_n)
        evt.tmr0_cmpa |=> status[5];
    endproperty
    a_status_set: assert property (p_status_set) else $error("status bit not set");

    property p_irq_on;
        @(posedge mclk) disable iff (!rst_n)
        (|(status & mask)) |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    property p_irq_off;
        @(posedge mclk) disable iff (!rst_n)
        !(|(status & mask)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without cause");

    property p_rd_unmapped;
        @(posedge mclk) disable iff (!rst_n)
        (bus.rd && bus.addr > mfirq_pkg::MFIRQ_ADDR_MASK) |=> rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_tm;
        @(posedge mclk) disable iff (!rst_n)
        (bus.rd && bus.addr == mfirq_pkg::MFIRQ_ADDR_TMR0_CTRL) |=> rdata == $past(tmr_ctrl);
    endproperty
    a_rd_tm: assert property (p_rd_tm) else $error("timer0 read wrong");

    property p_rd_pe;
        @(posedge mclk) disable iff (!rst_n)
        (bus.rd && bus.addr == mfirq_pkg::MFIRQ_ADDR_PERIPH) |=> rdata == $past(per_ctrl);
    endproperty
    a_rd_pe: assert property (p_rd_pe) else $error("peripheral read wrong");

    property p_hi3_hold;
        @(posedge mclk) disable iff (!rst_n)
        (!w_hi && hi_ctrl[5]) |=> hi_ctrl[5];
    endproperty
    a_hi3_hold: assert property (p_hi3_hold) else $error("group3 flag lost");

    property p_hi2_hold;
        @(posedge mclk) disable iff (!rst_n)
        (!w_hi && hi_ctrl[4]) |=> hi_ctrl[4];
    endproperty
    a_hi2_hold: assert property (p_hi2_hold) else $error("group2 flag lost");

    property p_rd_idle;
        @(posedge mclk) disable iff (!rst_n)
        !bus.rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

    property p_mask_keep;
        @(posedge mclk) disable iff (!rst_n)
        !w_mk |=> mask == $past(mask);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask moved");
endmodule // mfirq_regs

// ==== tb/mfirq_evt_src.sv ====
// peripheral event source model for the interrupt register slice
// assumes fire and bitn change just after a rising edge of mclk
`timescale 1ns/1ps
module mfirq_evt_src (
    input  wire logic             mclk,
    input  wire logic             fire,
    input  wire logic [2:0]       bitn,
    output mfirq_pkg::mfirq_evt_t evt
);
    // single-cycle pulse: a held event would hide a missing edge capture
    always @(posedge mclk) begin
        evt <= fire ? mfirq_pkg::mfirq_evt_t'(6'h01 << bitn) : mfirq_pkg::mfirq_evt_t'(6'h00);
    end
endmodule // mfirq_evt_src

// ==== tb/tb.sv ====
// self-checking bench for the interrupt register slice
// assumes fixed read and event latencies of the register port
`timescale 1ns/1ps
module tb;
    logic                  mclk = 1'b0;
    logic                  rst_n = 1'b0;
    mfirq_pkg::mfirq_bus_t bus = '0;
    logic [7:0]            rdata;
    mfirq_pkg::mfirq_evt_t evt;
    logic                  group2_irq, group3_irq, irq;
    logic                  fire = 1'b0;
    logic [2:0]            bitn = 3'h0;
    int                    error_cnt = 0;
    int                    comparisons = 0;
    integer                seed = 65;
    logic [7:0]            d;
    logic                  en;
    always #2.5 mclk = ~mclk;
    mfirq_regs mfirq_regs_i (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .evt(evt), .group2_irq(group2_irq), .group3_irq(group3_irq), .irq(irq));
    mfirq_evt_src mfirq_evt_src_i (.mclk(mclk), .fire(fire), .bitn(bitn), .evt(evt));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // status bit of an event; also its bit in the event carrier
    function automatic int stat_bit(input int s);
        return (s < 2) ? 5 - s : s - 2;
    endfunction
    function automatic int flag_bit(input int s);
        return (s < 2) ? 5 - s : s + 2;
    endfunction
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(4'h1, d);
            rd(4'h1, d & 8'h33);
            wr(4'h2, ~d);
            rd(4'h2, ~d);
            // sub-sources cleared first so no group set races the write below
            wr(4'h1, 8'h00);
            wr(4'h2, 8'h00);
            wr(4'h0, d);
            rd(4'h0, d & 8'h33);
            wr(4'hf, d);
            rd(4'hf, 8'h00);
        end
        // events with enables on, then off; global enable dropped once
        for (int i = 0; i < 12; i++) begin
            en = (i < 6);
            wr(4'h1, en ? 8'h0f : 8'h00);
            wr(4'h2, en ? 8'h0f : 8'h00);
            wr(4'h0, 8'h03);
            wr(4'h3, {7'h00, i != 5});
            wr(4'h4, 8'h3f);
            wr(4'h5, 8'h3f);
            #1 check({6'h00, group3_irq, group2_irq}, 8'h00);
            check({7'h00, irq}, 8'h00);
            @(posedge mclk);
            fire <= 1'b1;
            bitn <= 3'(stat_bit(i % 6));
            @(posedge mclk);
            fire <= 1'b0;
            repeat (4) @(posedge mclk);
            #1 check({6'h00, group3_irq, group2_irq},
                     {6'h00, en && i >= 2 && i != 5, en && i < 2});
            check({7'h00, irq}, 8'h01);
            rd(4'h4, 8'h01 << stat_bit(i % 6));
            d = (8'h01 << flag_bit(i % 6)) | (en ? ((i % 6 < 2) ? 8'h03 : 8'h0f) : 8'h00);
            rd((i % 6 < 2) ? 4'h1 : 4'h2, d);
            rd(4'h0, 8'h03 | (en ? ((i % 6 < 2) ? 8'h10 : 8'h20) : 8'h00));
            wr(4'h5, 8'h00);
            // irq is registered from the mask, so it drops one edge after the write
            @(posedge mclk);
            #1 check({7'h00, irq}, 8'h00);
        end
        summarize();
    end
endmodule // tb
